/* File: logic/bsrf_pkg.sv */
// bank-0 special register file: offsets, per-location reset, keep and write masks
// assumes a byte-wide core data bus with 32 special locations per bank
package bsrf_pkg;

	localparam int BSRF_LOCS = 32;

	// bank locations
	localparam logic [4:0] OFS_INDIRECT_ACCESS = 5'h00;
	localparam logic [4:0] OFS_TIMER0_COUNT = 5'h01;
	localparam logic [4:0] OFS_PC_LOW_BYTE = 5'h02;
	localparam logic [4:0] OFS_CORE_STATUS_FLAGS = 5'h03;
	localparam logic [4:0] OFS_INDIRECT_POINTER = 5'h04;
	localparam logic [4:0] OFS_PORT_A_PINS = 5'h05;
	localparam logic [4:0] OFS_PORT_B_PINS = 5'h06;
	localparam logic [4:0] OFS_PERIPH_IRQ_FLAGS_ONE = 5'h07;
	localparam logic [4:0] OFS_PERIPH_IRQ_FLAGS_TWO = 5'h08;
	localparam logic [4:0] OFS_RESET_CAUSE_FLAGS = 5'h09;
	localparam logic [4:0] OFS_PC_HIGH_LATCH = 5'h0A;
	localparam logic [4:0] OFS_IRQ_CONTROL = 5'h0B;
	localparam logic [4:0] OFS_TIMER1_COUNT_LOW = 5'h0C;
	localparam logic [4:0] OFS_TIMER1_COUNT_HIGH = 5'h0D;
	localparam logic [4:0] OFS_TIMER1_SETUP = 5'h0E;
	localparam logic [4:0] OFS_TIMER2_COUNT = 5'h0F;
	localparam logic [4:0] OFS_TIMER2_SETUP = 5'h10;
	localparam logic [4:0] OFS_TIMER2_PERIOD = 5'h11;
	localparam logic [4:0] OFS_SECONDARY_PHASE_LOW = 5'h13;
	localparam logic [4:0] OFS_SECONDARY_PHASE_HIGH = 5'h14;
	localparam logic [4:0] OFS_PWM_DUTY_LOW = 5'h15;
	localparam logic [4:0] OFS_PWM_DUTY_HIGH = 5'h16;
	localparam logic [4:0] OFS_REFERENCE_DAC_PRIMARY = 5'h19;
	localparam logic [4:0] OFS_REFERENCE_DAC_SECONDARY = 5'h1A;
	localparam logic [4:0] OFS_OSCILLATOR_TRIM = 5'h1B;
	localparam logic [4:0] OFS_CONVERSION_RESULT_LOW = 5'h1C;
	localparam logic [4:0] OFS_CONVERSION_RESULT_HIGH = 5'h1D;
	localparam logic [4:0] OFS_CONVERTER_CONTROL_ZERO = 5'h1E;
	localparam logic [4:0] OFS_CONVERTER_CONTROL_ONE = 5'h1F;

	// field positions and widths
	localparam int CONV_ON_BIT = 0;
	localparam int CONV_GO_BIT = 1;
	localparam int CONV_CHAN_LSB = 2;
	localparam int CONV_CLK_LSB = 4;
	localparam int PC_HIGH_BITS = 5;
	localparam int RESULT_BITS = 10;

	// location implemented as storage in this block (00h and result bytes handled apart)
	localparam logic [31:0] BSRF_STORED = 32'hCE7B_FFFE;

	// reset value after power-on (undefined bytes come up as zero)
	localparam logic [7:0] BSRF_RST [BSRF_LOCS] = '{
		8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// bits that survive a non power-on reset
	localparam logic [7:0] BSRF_KEEP [BSRF_LOCS] = '{
		8'h00, 8'hFF, 8'h00, 8'h07, 8'hFF, 8'hEF, 8'hF3, 8'h00,
		8'h00, 8'h03, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h33, 8'hFF,
		8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h00, 8'h00};

	// bits software may write; the rest read back as held or as zero
	localparam logic [7:0] BSRF_WMASK [BSRF_LOCS] = '{
		8'h00, 8'hFF, 8'hFF, 8'hE7, 8'hFF, 8'hEF, 8'hF3, 8'h7F,
		8'h9F, 8'h03, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'h33, 8'hFF,
		8'h07, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
		8'h00, 8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h7F, 8'h70};

endpackage : bsrf_pkg

/* File: logic/bsrf_byte_reg.sv */
// one special register byte with power-on value, per-bit keep on soft reset
// assumes set and clear strobes come from peripheral logic in the same clock
`timescale 1ns/10ps
module bsrf_byte_reg #(
	parameter logic [7:0] RST = 8'h00,
	parameter logic [7:0] KEEP = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF
) (
	// clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic soft_rst,
	// software write
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// hardware events
	input wire logic [7:0] hw_set,
	input wire logic [7:0] hw_clr,
	// value
	output logic [7:0] q
);

	logic [7:0] q_next;

	// set applied last so an event beside a clearing write is kept
	always_comb
	begin
		q_next = q;
		if (wr_en)
		begin
			q_next = (q & ~WMASK) | (wdata & WMASK);
		end
		q_next = (q_next & ~hw_clr) | hw_set;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= RST;
		end
		else if (soft_rst)
		begin
			q <= (q & KEEP) | (RST & ~KEEP);
		end
		else
		begin
			q <= q_next;
		end
	end

endmodule : bsrf_byte_reg

/* File: logic/bsrf_result_cap.sv */
// captures a finished 10-bit conversion into result low and high bytes
// assumes conv_done is a one-cycle pulse with conv_result valid beside it
`timescale 1ns/10ps
module bsrf_result_cap
	import bsrf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// converter
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] conv_result,
	// result bytes
	output logic [7:0] res_low,
	output logic [7:0] res_high
);

	logic [1:0] res_top_reg;

	// no soft reset input: both bytes hold through non power-on resets
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			res_low <= 8'h00;
			res_top_reg <= 2'h0;
		end
		else if (conv_done)
		begin
			res_low <= conv_result[7:0]; // [RQ5]
			res_top_reg <= conv_result[RESULT_BITS-1:8];
		end
	end

	assign res_high = {6'h00, res_top_reg}; // [RQ4]

endmodule : bsrf_result_cap

/* File: logic/bsrf_bank0.sv */
// bank-0 special register file of the controller core
// assumes the core drives one-cycle strobes and data memory answers indirect
// accesses combinationally in the cycle of the request
//
// Contract
// (RQ1) location 00h accesses memory at indirect pointer
// (RQ2) pc high latch, 5 bits, cleared every reset
// (RQ3) timer1 count bytes at 0Ch/0Dh, kept
// (RQ4) result high: top two bits, upper zero
// (RQ5) result low: lower eight bits, kept
// (RQ6) pwm duty bytes at 15h/16h, kept
// (RQ7) secondary phase bytes at 13h/14h, kept
// (RQ8) 12h, 17h, 18h read zero, ignore writes
`timescale 1ns/10ps
module bsrf_bank0
	import bsrf_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	// clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic soft_rst,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// indirect data memory path
	output logic [7:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_wr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	// program counter load
	output logic pc_load,
	output logic [12:0] pc_load_value,
	// peripheral events
	input wire logic [7:0] irq_set_one,
	input wire logic [7:0] irq_set_two,
	input wire logic [1:0] reset_cause_set,
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] conv_result,
	// register values toward the core and peripherals
	output logic [7:0] core_status,
	output logic [7:0] irq_control,
	output logic [7:0] irq_flags_one,
	output logic [7:0] irq_flags_two,
	output logic [PC_HIGH_BITS-1:0] pc_high,
	output logic [7:0] timer0_value,
	output logic [15:0] timer1_value,
	output logic [7:0] timer1_mode,
	output logic [7:0] timer2_value,
	output logic [7:0] timer2_mode,
	output logic [7:0] timer2_limit,
	output logic [15:0] secondary_phase,
	output logic [15:0] pwm_duty,
	output logic [7:0] ref_dac_primary,
	output logic [7:0] ref_dac_secondary,
	output logic [4:0] osc_trim,
	output logic conv_enable,
	output logic conv_start,
	output logic [4:0] conv_channel,
	output logic [2:0] conv_clock_sel
);

	generate
		if (ADDR_W < 5)
		begin : g_addr_chk
			$error("bsrf_bank0: ADDR_W must cover 32 locations");
		end
		if (BSRF_LOCS != 32)
		begin : g_locs_chk
			$error("bsrf_bank0: the location decode is five bits wide");
		end
		if (RESULT_BITS != 10)
		begin : g_res_chk
			$error("bsrf_bank0: result bytes are laid out for a 10-bit result");
		end
		if (PC_HIGH_BITS > 8)
		begin : g_pch_chk
			$error("bsrf_bank0: pc high latch must fit in one byte");
		end
	endgenerate

	// how a port address is served
	typedef enum logic [4:0] {
		LOC_FOREIGN = 5'h01,
		LOC_INDIRECT = 5'h02,
		LOC_STORED = 5'h04,
		LOC_RESULT = 5'h08,
		LOC_EMPTY = 5'h10
	} bsrf_loc_kind_e;

	logic [7:0] bank_q [BSRF_LOCS];
	logic [7:0] set_v [BSRF_LOCS];
	logic [7:0] clr_v [BSRF_LOCS];
	logic [BSRF_LOCS-1:0] wr_sel;
	logic in_bank;
	logic [4:0] loc;
	bsrf_loc_kind_e kind;
	logic [7:0] res_low;
	logic [7:0] res_high;
	logic [7:0] rdata_next;
	logic pc_load_reg;
	logic [12:0] pc_load_value_reg;

	// shared by the indirect path and the read mux so both agree on a place
	function automatic bsrf_loc_kind_e loc_kind(input logic [ADDR_W-1:0] a);
		logic [4:0] l;
		l = a[4:0];
		if ((a >> 5) != '0)
		begin
			loc_kind = LOC_FOREIGN;
		end
		else if (l == OFS_INDIRECT_ACCESS)
		begin
			loc_kind = LOC_INDIRECT;
		end
		else if (BSRF_STORED[l])
		begin
			loc_kind = LOC_STORED;
		end
		else if (l == OFS_CONVERSION_RESULT_LOW || l == OFS_CONVERSION_RESULT_HIGH)
		begin
			loc_kind = LOC_RESULT;
		end
		else
		begin
			loc_kind = LOC_EMPTY;
		end
	endfunction : loc_kind

	// locations above 1Fh are general purpose memory, not this block
	assign in_bank = (addr >> 5) == '0;
	assign loc = addr[4:0];
	assign kind = loc_kind(addr);

	// write decode; location 00h and non-stored places never get a strobe
	always_comb
	begin
		wr_sel = '0;
		if (wr && in_bank && BSRF_STORED[loc])
		begin
			wr_sel[loc] = 1'b1; // [RQ8]
		end
	end

	// hardware events per location; peripheral behaviour itself is outside
	always_comb
	begin
		for (int i = 0; i < BSRF_LOCS; i++)
		begin
			set_v[i] = 8'h00;
			clr_v[i] = 8'h00;
		end
		set_v[OFS_PERIPH_IRQ_FLAGS_ONE] = irq_set_one & BSRF_WMASK[OFS_PERIPH_IRQ_FLAGS_ONE];
		set_v[OFS_PERIPH_IRQ_FLAGS_TWO] = irq_set_two & BSRF_WMASK[OFS_PERIPH_IRQ_FLAGS_TWO];
		set_v[OFS_RESET_CAUSE_FLAGS] = {6'h00, reset_cause_set};
		// a finished conversion drops the go bit
		clr_v[OFS_CONVERTER_CONTROL_ZERO][CONV_GO_BIT] = conv_done;
	end

	// stored registers, one instance per implemented location
	genvar g;
	generate
		for (g = 0; g < BSRF_LOCS; g++)
		begin : g_loc
			// a place with no storage must not claim writable bits
			if (!BSRF_STORED[g] && BSRF_WMASK[g] != 8'h00)
			begin : g_map_chk
				$error("bsrf_bank0: writable bits mapped onto a place without storage");
			end
			if (BSRF_STORED[g])
			begin : g_reg
				bsrf_byte_reg #(
					.RST(BSRF_RST[g]),
					.KEEP(BSRF_KEEP[g]),
					.WMASK(BSRF_WMASK[g])
				) u_reg (
					.clk(clk),
					.rstn(rstn),
					.soft_rst(soft_rst),
					.wr_en(wr_sel[g]),
					.wdata(wdata),
					.hw_set(set_v[g]),
					.hw_clr(clr_v[g]),
					.q(bank_q[g])
				);
			end
			else if (g == OFS_CONVERSION_RESULT_LOW)
			begin : g_res_low
				assign bank_q[g] = res_low; // [RQ5]
			end
			else if (g == OFS_CONVERSION_RESULT_HIGH)
			begin : g_res_high
				assign bank_q[g] = res_high; // [RQ4]
			end
			else
			begin : g_none
				// 00h has no storage; 12h, 17h, 18h are empty
				assign bank_q[g] = 8'h00; // [RQ1] [RQ8]
			end
		end
	endgenerate

	// result bytes are loaded by the converter, never by software
	bsrf_result_cap u_result (
		.clk(clk),
		.rstn(rstn),
		.conv_done(conv_done),
		.conv_result(conv_result),
		.res_low(res_low),
		.res_high(res_high)
	);

	// indirect access steered through the pointer register
	always_comb
	begin
		mem_addr = bank_q[OFS_INDIRECT_POINTER]; // [RQ1]
		mem_wdata = wdata;
		mem_wr = wr && (kind == LOC_INDIRECT); // [RQ1]
		mem_rd = rd && (kind == LOC_INDIRECT); // [RQ1]
	end

	// read mux; unmapped and out-of-bank places answer zero
	always_comb
	begin
		rdata_next = 8'h00;
		case (kind)
			LOC_INDIRECT:
			begin
				rdata_next = mem_rdata; // [RQ1]
			end
			LOC_STORED:
			begin
				rdata_next = bank_q[loc];
			end
			LOC_RESULT:
			begin
				rdata_next = bank_q[loc]; // [RQ4] [RQ5]
			end
			LOC_EMPTY:
			begin
				rdata_next = 8'h00; // [RQ8]
			end
			default:
			begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata <= 8'h00;
		end
		else if (rd)
		begin
			rdata <= rdata_next;
		end
		else
		begin
			rdata <= 8'h00;
		end
	end

	// writing the low pc byte loads the whole counter from the latch and the written byte
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc_load_reg <= 1'b0;
			pc_load_value_reg <= 13'h0000;
		end
		else if (soft_rst)
		begin
			pc_load_reg <= 1'b0; // a write beside a soft reset is beaten
		end
		else
		begin
			pc_load_reg <= wr_sel[OFS_PC_LOW_BYTE];
			if (wr_sel[OFS_PC_LOW_BYTE])
			begin
				pc_load_value_reg <= {bank_q[OFS_PC_HIGH_LATCH][PC_HIGH_BITS-1:0], wdata}; // [RQ2]
			end
		end
	end

	assign pc_load = pc_load_reg;
	assign pc_load_value = pc_load_value_reg;

	// register values out
	assign core_status = bank_q[OFS_CORE_STATUS_FLAGS];
	assign irq_control = bank_q[OFS_IRQ_CONTROL];
	assign irq_flags_one = bank_q[OFS_PERIPH_IRQ_FLAGS_ONE];
	assign irq_flags_two = bank_q[OFS_PERIPH_IRQ_FLAGS_TWO];
	assign pc_high = bank_q[OFS_PC_HIGH_LATCH][PC_HIGH_BITS-1:0]; // [RQ2]
	assign timer0_value = bank_q[OFS_TIMER0_COUNT];
	// no timer behind these bytes here; they hold what software wrote
	assign timer1_value = {bank_q[OFS_TIMER1_COUNT_HIGH], bank_q[OFS_TIMER1_COUNT_LOW]}; // [RQ3]
	assign timer1_mode = bank_q[OFS_TIMER1_SETUP];
	assign timer2_value = bank_q[OFS_TIMER2_COUNT];
	assign timer2_mode = bank_q[OFS_TIMER2_SETUP];
	assign timer2_limit = bank_q[OFS_TIMER2_PERIOD];
	assign secondary_phase = {bank_q[OFS_SECONDARY_PHASE_HIGH],
		bank_q[OFS_SECONDARY_PHASE_LOW]}; // [RQ7]
	assign pwm_duty = {bank_q[OFS_PWM_DUTY_HIGH], bank_q[OFS_PWM_DUTY_LOW]}; // [RQ6]
	assign ref_dac_primary = bank_q[OFS_REFERENCE_DAC_PRIMARY];
	assign ref_dac_secondary = bank_q[OFS_REFERENCE_DAC_SECONDARY];
	assign osc_trim = bank_q[OFS_OSCILLATOR_TRIM][4:0];
	assign conv_enable = bank_q[OFS_CONVERTER_CONTROL_ZERO][CONV_ON_BIT];
	assign conv_start = bank_q[OFS_CONVERTER_CONTROL_ZERO][CONV_GO_BIT];
	assign conv_channel = bank_q[OFS_CONVERTER_CONTROL_ZERO][CONV_CHAN_LSB +: 5];
	assign conv_clock_sel = bank_q[OFS_CONVERTER_CONTROL_ONE][CONV_CLK_LSB +: 3];

endmodule : bsrf_bank0

/* File: tb/bsrf_bank0_asserts.sv */
// checker for the bank-0 register port, indirect path and reset keeping
// assumes it is bound to bsrf_bank0 and sees only its ports
`timescale 1ns/10ps
module bsrf_bank0_asserts
	import bsrf_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	// clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic soft_rst,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// memory path
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [7:0] mem_rdata,
	// converter and values
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] conv_result,
	input wire logic [PC_HIGH_BITS-1:0] pc_high,
	input wire logic [15:0] timer1_value,
	input wire logic [15:0] pwm_duty,
	input wire logic [15:0] secondary_phase
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_ind_read: assert property (rd && addr == 7'h00 |-> mem_rd ##1 rdata == $past(mem_rdata))
		else $error("indirect read not passed through");
	a_ind_write: assert property (wr && addr == 7'h00 |-> mem_wr && mem_wdata == wdata)
		else $error("indirect write not passed through");
	a_pch_write: assert property (wr && addr == 7'h0A && !soft_rst |=> pc_high == $past(wdata[4:0]))
		else $error("pc high latch write lost");
	a_pch_clear: assert property (soft_rst |=> pc_high == 5'h00)
		else $error("pc high latch not cleared");
	a_t1_keep: assert property (soft_rst |=> $stable(timer1_value))
		else $error("timer1 count changed on soft reset");
	a_reshi_zero: assert property (rd && addr == 7'h1D |=> rdata[7:2] == 6'h00)
		else $error("result high upper bits not zero");
	a_reslo_load: assert property (conv_done && !soft_rst ##1 (rd && addr == 7'h1C && !conv_done)
		|=> rdata == $past(conv_result[7:0], 2))
		else $error("result low not captured");
	a_duty_keep: assert property (soft_rst |=> $stable(pwm_duty) && $stable(secondary_phase))
		else $error("duty or phase changed on soft reset");
	a_duty_write: assert property (wr && addr == 7'h15 && !soft_rst |=> pwm_duty[7:0] == $past(wdata))
		else $error("duty low write lost");
	a_unimpl_zero: assert property (rd && (addr == 7'h12 || addr == 7'h17 || addr == 7'h18)
		|=> rdata == 8'h00)
		else $error("unimplemented location read nonzero");
endmodule : bsrf_bank0_asserts

bind bsrf_bank0 bsrf_bank0_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rstn(rstn),
	.soft_rst(soft_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
	.conv_done(conv_done), .conv_result(conv_result), .pc_high(pc_high),
	.timer1_value(timer1_value), .pwm_duty(pwm_duty), .secondary_phase(secondary_phase));

/* File: tb/bsrf_bank0_tb.sv */
// self-checking bench for the bank-0 register file
// assumes one 25 MHz clock; irq_set_two and reset_cause_set are tied idle
`timescale 1ns/10ps
module bsrf_bank0_tb;
	logic clk, rstn, soft_rst, wr, rd, conv_done, mem_wr, mem_rd, pc_load, conv_go;
	logic [6:0] addr;
	logic [7:0] wdata, rdata, mem_rdata, mem_addr, mem_wdata, irq_set, irq_one;
	logic [12:0] pc_load_value;
	logic [4:0] pc_high;
	logic [15:0] timer1_value, pwm_duty, secondary_phase;
	logic [9:0] conv_result;
	int mismatches, total_checks, i;
	logic [6:0] tab_a [4] = '{7'h13, 7'h14, 7'h15, 7'h16};
	logic [7:0] tab_d [4] = '{8'hC1, 8'h5E, 8'hA7, 8'h3B};
	logic [6:0] bad_a [4] = '{7'h12, 7'h17, 7'h18, 7'h40};

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	bsrf_bank0 #(.ADDR_W(7)) dut (.clk(clk), .rstn(rstn), .soft_rst(soft_rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .irq_set_one(irq_set),
		.irq_set_two(8'h00), .reset_cause_set(2'h0), .conv_done(conv_done),
		.conv_result(conv_result), .core_status(), .irq_control(), .irq_flags_one(irq_one),
		.irq_flags_two(), .pc_high(pc_high), .timer0_value(), .timer1_value(timer1_value),
		.timer1_mode(), .timer2_value(), .timer2_mode(), .timer2_limit(),
		.secondary_phase(secondary_phase), .pwm_duty(pwm_duty), .ref_dac_primary(),
		.ref_dac_secondary(), .osc_trim(), .conv_enable(), .conv_start(conv_go), .conv_channel(),
		.conv_clock_sel());

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// rdata stands one cycle only, so it is taken right after the edge
	task rd_chk(input string n, input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(n, rdata, exp);
	endtask : rd_chk

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		#2000000;
		mismatches++;
		end_sim;
	end

	initial
	begin
		{rstn, soft_rst, wr, rd, conv_done} = 5'h00;
		addr = 7'h00;
		wdata = 8'h00;
		mem_rdata = 8'h00;
		irq_set = 8'h00;
		conv_result = 10'h000;
		mismatches = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd_chk("latch por", 7'h0A, 8'h00);
		rd_chk("period por", 7'h11, 8'hFF);
		wr_reg(7'h04, 8'h3C);
		@(posedge clk);
		addr <= 7'h00;
		wdata <= 8'hA5;
		wr <= 1'b1;
		mem_rdata <= 8'h96;
		#1 check("mem_wr", mem_wr, 16'h0001);
		check("mem_addr", mem_addr, 16'h003C);
		check("mem_wdata", mem_wdata, 16'h00A5);
		@(posedge clk);
		wr <= 1'b0;
		rd_chk("indirect", 7'h00, 8'h96);
		wr_reg(7'h0A, 8'hFF);
		check("pc_high", pc_high, 16'h001F);
		rd_chk("latch", 7'h0A, 8'h1F);
		wr_reg(7'h02, 8'h34);
		check("pc_load", pc_load, 16'h0001);
		check("pc_load_value", pc_load_value, 16'h1F34);
		wr_reg(7'h0C, 8'h11);
		wr_reg(7'h0D, 8'h22);
		check("timer1", timer1_value, 16'h2211);
		for (i = 0; i < 4; i++)
			wr_reg(tab_a[i], tab_d[i]);
		check("duty", pwm_duty, 16'h3BA7);
		check("phase", secondary_phase, 16'h5EC1);
		@(posedge clk);
		conv_done <= 1'b1;
		conv_result <= 10'h2B7;
		@(posedge clk);
		conv_done <= 1'b0;
		addr <= 7'h1C;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check("result low", rdata, 16'h00B7);
		wr_reg(7'h1C, 8'h00);
		wr_reg(7'h1D, 8'hFC);
		// soft reset: of the bytes read back, only the pc latch may move
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		rd_chk("latch soft", 7'h0A, 8'h00);
		rd_chk("timer1 low", 7'h0C, 8'h11);
		rd_chk("timer1 high", 7'h0D, 8'h22);
		for (i = 0; i < 4; i++)
			rd_chk("duty phase", tab_a[i], tab_d[i]);
		rd_chk("result low", 7'h1C, 8'hB7);
		rd_chk("result high", 7'h1D, 8'h02);
		for (i = 0; i < 4; i++)
		begin
			wr_reg(bad_a[i], 8'hFF);
			rd_chk("unimplemented", bad_a[i], 8'h00);
		end
		// an event beside a clearing write must survive
		@(posedge clk);
		irq_set <= 8'h41;
		addr <= 7'h07;
		wdata <= 8'h00;
		wr <= 1'b1;
		@(posedge clk);
		irq_set <= 8'h00;
		wr <= 1'b0;
		#1 check("flag set wins", irq_one, 16'h0041);
		wr_reg(7'h07, 8'h00);
		check("flag clear", irq_one, 16'h0000);
		// a finished conversion drops the go bit
		wr_reg(7'h1E, 8'h03);
		check("go set", conv_go, 16'h0001);
		@(posedge clk);
		conv_done <= 1'b1;
		@(posedge clk);
		conv_done <= 1'b0;
		#1 check("go cleared", conv_go, 16'h0000);
		end_sim;
	end
endmodule : bsrf_bank0_tb
